// ---- verilog/dsp_decoder_pkg.sv ----
// Package holding encodings, fields and cycle counts for the decoder
package dsp_decoder_pkg;

    // Instruction word fields
    localparam int WORD_W = 16;
    localparam int OPC_HI = 15;
    localparam int OPC_LO = 8;
    localparam int MODE_BIT = 7;
    localparam int INC_BIT = 5;
    localparam int DEC_BIT = 4;
    localparam int KEEP_PTR_BIT = 3;
    localparam int PTR_BIT = 0;
    localparam int DMA_HI = 6;
    localparam int DATA_ADDR_W = 8;
    localparam int AUX_W = 16;
    localparam int PORT_LO = 8;
    localparam int PORT_W = 3;
    localparam int SHIFT4_LO = 8;
    localparam int SHIFT3_LO = 8;
    localparam int PICK_BIT = 8;
    localparam int K13_W = 13;
    localparam int K8_W = 8;

    // Cycle counts per class
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;

    // Reset values
    localparam logic [AUX_W-1:0] AUX_RESET = 16'h0000;
    localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

    // Instruction classes produced by the decoder
    typedef enum logic [4:0] {
        OP_NOP = 5'b00000,
        OP_ADD_SHIFT = 5'b00001,
        OP_SUB_SHIFT = 5'b00010,
        OP_LOAD_SHIFT = 5'b00011,
        OP_PLUS_UNEXT = 5'b00100,
        OP_CLEAR_LOAD_HI = 5'b00101,
        OP_UPPER_STORE = 5'b00110,
        OP_AUX_LOAD_DIR = 5'b00111,
        OP_AUX_LOAD_IMM = 5'b01000,
        OP_AUX_STORE = 5'b01001,
        OP_PTR_LOAD_IMM = 5'b01010,
        OP_PORT_IN = 5'b01011,
        OP_PORT_OUT = 5'b01100,
        OP_TABLE_READ = 5'b01101,
        OP_TABLE_WRITE = 5'b01110,
        OP_DATA_SHIFT = 5'b01111,
        OP_T_LOAD_MOVE = 5'b10000,
        OP_IMM_MULTIPLY = 5'b10001,
        OP_CALL_ACC = 5'b10010,
        OP_POP_PC = 5'b10011,
        OP_PUSH_ACC = 5'b10100,
        OP_POP_ACC = 5'b10101,
        OP_JUMP_ACC = 5'b10110,
        OP_LOOP_AUX = 5'b10111,
        OP_OTHER_MEM = 5'b11000
    } op_class_t;

    // Accumulator branch conditions
    typedef enum logic [2:0] {
        COND_ZERO = 3'b000,
        COND_NONZERO = 3'b001,
        COND_POS = 3'b010,
        COND_NONNEG = 3'b011,
        COND_NEG = 3'b100,
        COND_NONPOS = 3'b101
    } jump_cond_t;

    // Decoded command sent to the datapath
    typedef struct packed {
        op_class_t opClass;
        logic [1:0] cycles;
        logic [DATA_ADDR_W-1:0] dataAddr;
        logic usesMemory;
        logic [3:0] loadShift;
        logic [2:0] storeShift;
        logic [PORT_W-1:0] ioChannel;
        logic auxPick;
        logic [K13_W-1:0] immediate;
        jump_cond_t cond;
        logic [WORD_W-1:0] target;
        logic takeJump;
    } decoded_t;

    // Opcode patterns of the bits above the operand fields
    localparam logic [7:0] PAT_LOAD_SHIFT_HI = 8'h20;
    localparam logic [3:0] PAT_ADD_HI = 4'h0;
    localparam logic [3:0] PAT_SUB_HI = 4'h1;
    localparam logic [3:0] PAT_LOAD_HI = 4'h2;
    localparam logic [7:0] PAT_PLUS_UNEXT = 8'h61;
    localparam logic [7:0] PAT_CLEAR_LOAD_HI = 8'h65;
    localparam logic [4:0] PAT_UPPER_STORE = 5'h0b;
    localparam logic [6:0] PAT_AUX_LOAD_DIR = 7'h1c;
    localparam logic [6:0] PAT_AUX_LOAD_IMM = 7'h38;
    localparam logic [6:0] PAT_AUX_STORE = 7'h18;
    localparam logic [14:0] PAT_PTR_LOAD = 15'h3440;
    localparam logic [4:0] PAT_PORT_IN = 5'h08;
    localparam logic [4:0] PAT_PORT_OUT = 5'h09;
    localparam logic [7:0] PAT_TABLE_READ = 8'h67;
    localparam logic [7:0] PAT_TABLE_WRITE = 8'h7d;
    localparam logic [7:0] PAT_DATA_SHIFT = 8'h69;
    localparam logic [7:0] PAT_T_LOAD_MOVE = 8'h6b;
    localparam logic [2:0] PAT_IMM_MULTIPLY = 3'h4;
    localparam logic [15:0] PAT_CALL_ACC = 16'h7f8c;
    localparam logic [15:0] PAT_POP_PC = 16'h7f8d;
    localparam logic [15:0] PAT_PUSH_ACC = 16'h7f9c;
    localparam logic [15:0] PAT_POP_ACC = 16'h7f9d;
    localparam logic [15:0] PAT_LOOP_AUX = 16'hf400;
    localparam logic [15:0] PAT_JZ = 16'hff00;
    localparam logic [15:0] PAT_JNZ = 16'hfe00;
    localparam logic [15:0] PAT_JPOS = 16'hfc00;
    localparam logic [15:0] PAT_JNNEG = 16'hfd00;
    localparam logic [15:0] PAT_JNEG = 16'hfa00;
    localparam logic [15:0] PAT_JNPOS = 16'hfb00;
    localparam logic [7:0] PAT_OTHER_MEM_HI = 8'h60;

endpackage

// ---- verilog/aux_unit.sv ----
// Auxiliary register pair with pointer and post-modify arithmetic
`timescale 1ns/1ps
module aux_unit
    import dsp_decoder_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Update controls from the decoder
    input wire logic step,
    input wire logic indirect,
    input wire logic [WORD_W-1:0] word,
    input wire logic loadEn,
    input wire logic loadPick,
    input wire logic [AUX_W-1:0] loadValue,
    input wire logic ptrLoadEn,
    input wire logic ptrLoadValue,
    // State seen by the decoder
    output logic [AUX_W-1:0] aux0,
    output logic [AUX_W-1:0] aux1,
    output logic auxPointer
);

    // Post-modify value: increment wins if both bits are set
    function automatic logic [AUX_W-1:0] modify(
        input logic [AUX_W-1:0] value,
        input logic [WORD_W-1:0] w
    );
        if (w[INC_BIT]) begin
            modify = value + 16'h0001; // see (RULE1)
        end else if (w[DEC_BIT]) begin
            modify = value - 16'h0001; // see (RULE2)
        end else begin
            modify = value; // see (RULE3)
        end
    endfunction

    // Register 0: explicit loads take priority over post-modify
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            aux0 <= AUX_RESET;
        end else if (step && loadEn && !loadPick) begin
            aux0 <= loadValue; // see (RULE8)
        end else if (step && indirect && !auxPointer) begin
            aux0 <= modify(aux0, word); // see (RULE1) (RULE2) (RULE3)
        end
    end

    // Register 1: same scheme
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            aux1 <= AUX_RESET;
        end else if (step && loadEn && loadPick) begin
            aux1 <= loadValue; // see (RULE8)
        end else if (step && indirect && auxPointer) begin
            aux1 <= modify(aux1, word); // see (RULE1) (RULE2) (RULE3)
        end
    end

    // Pointer: immediate load, or bit 0 when bit 3 is clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            auxPointer <= 1'b0;
        end else if (step && ptrLoadEn) begin
            auxPointer <= ptrLoadValue; // see (RULE22)
        end else if (step && indirect && !word[KEEP_PTR_BIT]) begin
            auxPointer <= word[PTR_BIT]; // see (RULE25)
        end
    end

endmodule // aux_unit

// ---- verilog/dsp_instruction_decoder.sv ----
// Instruction decoder and sequencer for the fixed-point signal processor
`timescale 1ns/1ps
// How it works
// (RULE1) Bit 5 increments selected aux register
// (RULE2) Bit 4 decrements selected aux register
// (RULE3) Neither bit: aux registers unchanged
// (RULE4) Program keeps bits 6, 2, 1 zero
// (RULE5) Every memory instruction accepts indirect addressing
// (RULE6) Immediates take operand from instruction word
// (RULE7) Port instructions: 3-bit channel, two cycles
// (RULE8) Pick bit chooses aux register
// (RULE9) Upper store: 3-bit shift, one cycle
// (RULE10) Shifted add/sub/load: 4-bit shift, one cycle
// (RULE11) Plus unextended: no sign extension, one cycle
// (RULE12) Clear then load upper, one cycle
// (RULE13) Accumulator branches: two words, two cycles
// (RULE14) Loop branch if aux nonzero, two cycles
// (RULE15) Call via accumulator: one word, two cycles
// (RULE16) Pop to pc: one word, two cycles
// (RULE17) Push and pop accumulator: two cycles
// (RULE18) Table read/write: three cycles, one word
// (RULE19) Data shift copies to next address
// (RULE20) T load move: load, accumulate, copy
// (RULE21) Immediate multiply uses word constant
// (RULE22) Pointer immediate load from low bit
// (RULE23) Bit 7 clear: page joined with bits 6-0
// (RULE24) Indirect: address is low aux byte
// (RULE25) Bit 3 clear loads bit 0 into pointer
// (RULE26) Unknown opcode: one-cycle no-operation
module dsp_instruction_decoder
    import dsp_decoder_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Program memory fetch path
    input wire logic wordValid,
    input wire logic [WORD_W-1:0] wordIn,
    output logic wordTaken_q,
    // Datapath state the decoder reads
    input wire logic dataPage,
    input wire logic [31:0] accumulator,
    // Decoded command to the datapath
    output decoded_t command_q,
    output logic commandValid_q,
    // Auxiliary state and busy flag shown outward
    output logic [AUX_W-1:0] aux0Out_q,
    output logic [AUX_W-1:0] aux1Out_q,
    output logic auxPointerOut_q,
    output logic busy_q
);

    // Sequencer states
    typedef enum logic [1:0] {
        ST_FETCH = 2'b00,
        ST_SECOND = 2'b01,
        ST_EXEC = 2'b10
    } seq_state_t;

    seq_state_t state_q;
    logic [WORD_W-1:0] firstWord_q; // Opcode word held for two-word forms
    logic [1:0] waitCount_q; // Remaining execution cycles
    decoded_t dec; // Combinational decode of the incoming word
    logic needsSecond; // Decoded form has a second word
    logic indirect; // Word uses indirect addressing
    logic step; // Architectural update this cycle
    logic [AUX_W-1:0] aux0;
    logic [AUX_W-1:0] aux1;
    logic auxPointer;
    logic auxLoadEn;
    logic ptrLoadEn;

    // Memory operand address: direct or indirect
    function automatic logic [DATA_ADDR_W-1:0] operand_addr(
        input logic [WORD_W-1:0] w,
        input logic page,
        input logic [AUX_W-1:0] auxSel
    );
        if (w[MODE_BIT]) begin
            operand_addr = auxSel[DATA_ADDR_W-1:0]; // see (RULE24) (RULE5)
        end else begin
            operand_addr = {page, w[DMA_HI:0]}; // see (RULE23)
        end
    endfunction

    // Accumulator condition test
    function automatic logic cond_true(
        input jump_cond_t c,
        input logic [31:0] acc
    );
        logic zero;
        logic neg;
        zero = (acc == 32'h0000_0000);
        neg = acc[31];
        unique case (c)
            COND_ZERO: cond_true = zero;
            COND_NONZERO: cond_true = !zero;
            COND_POS: cond_true = !zero && !neg;
            COND_NONNEG: cond_true = !neg;
            COND_NEG: cond_true = neg;
            COND_NONPOS: cond_true = zero || neg;
            default: cond_true = 1'b0;
        endcase
    endfunction

    // Classify the word in front of the decoder
    always_comb begin
        logic [WORD_W-1:0] w;
        w = wordIn;
        dec = '0;
        dec.opClass = OP_NOP; // see (RULE26)
        dec.cycles = CYC_ONE;
        dec.cond = COND_ZERO;
        dec.dataAddr = operand_addr(w, dataPage, auxPointer ? aux1 : aux0);
        dec.loadShift = w[SHIFT4_LO +: 4];
        dec.storeShift = w[SHIFT3_LO +: 3];
        dec.ioChannel = w[PORT_LO +: PORT_W];
        dec.auxPick = w[PICK_BIT];
        needsSecond = 1'b0;
        if (w[15:13] == PAT_IMM_MULTIPLY) begin
            dec.opClass = OP_IMM_MULTIPLY; // see (RULE21) (RULE6)
            dec.immediate = w[K13_W-1:0];
        end else if (w[15:12] == PAT_ADD_HI) begin
            dec.opClass = OP_ADD_SHIFT; // see (RULE10)
        end else if (w[15:12] == PAT_SUB_HI) begin
            dec.opClass = OP_SUB_SHIFT; // see (RULE10)
        end else if (w[15:12] == PAT_LOAD_HI) begin
            dec.opClass = OP_LOAD_SHIFT; // see (RULE10)
        end else if (w[15:11] == PAT_UPPER_STORE) begin
            dec.opClass = OP_UPPER_STORE; // see (RULE9)
        end else if (w[15:11] == PAT_PORT_IN) begin
            dec.opClass = OP_PORT_IN; // see (RULE7)
            dec.cycles = CYC_TWO;
        end else if (w[15:11] == PAT_PORT_OUT) begin
            dec.opClass = OP_PORT_OUT; // see (RULE7)
            dec.cycles = CYC_TWO;
        end else if (w[15:9] == PAT_AUX_LOAD_DIR) begin
            dec.opClass = OP_AUX_LOAD_DIR; // see (RULE8)
        end else if (w[15:9] == PAT_AUX_STORE) begin
            dec.opClass = OP_AUX_STORE; // see (RULE8)
        end else if (w[15:9] == PAT_AUX_LOAD_IMM) begin
            dec.opClass = OP_AUX_LOAD_IMM; // see (RULE8) (RULE6)
            dec.immediate = {5'h00, w[K8_W-1:0]};
        end else if (w[15:1] == PAT_PTR_LOAD) begin
            dec.opClass = OP_PTR_LOAD_IMM; // see (RULE22)
            dec.immediate = {12'h000, w[0]};
        end else if (w[15:8] == PAT_PLUS_UNEXT) begin
            dec.opClass = OP_PLUS_UNEXT; // see (RULE11)
        end else if (w[15:8] == PAT_CLEAR_LOAD_HI) begin
            dec.opClass = OP_CLEAR_LOAD_HI; // see (RULE12)
        end else if (w[15:8] == PAT_TABLE_READ) begin
            dec.opClass = OP_TABLE_READ; // see (RULE18)
            dec.cycles = CYC_THREE;
        end else if (w[15:8] == PAT_TABLE_WRITE) begin
            dec.opClass = OP_TABLE_WRITE; // see (RULE18)
            dec.cycles = CYC_THREE;
        end else if (w[15:8] == PAT_DATA_SHIFT) begin
            dec.opClass = OP_DATA_SHIFT; // see (RULE19)
        end else if (w[15:8] == PAT_T_LOAD_MOVE) begin
            dec.opClass = OP_T_LOAD_MOVE; // see (RULE20)
        end else if (w == PAT_CALL_ACC) begin
            dec.opClass = OP_CALL_ACC; // see (RULE15)
            dec.cycles = CYC_TWO;
            dec.target = accumulator[WORD_W-1:0];
            dec.takeJump = 1'b1;
        end else if (w == PAT_POP_PC) begin
            dec.opClass = OP_POP_PC; // see (RULE16)
            dec.cycles = CYC_TWO;
            dec.takeJump = 1'b1;
        end else if (w == PAT_PUSH_ACC || w == PAT_POP_ACC) begin
            dec.opClass = (w == PAT_PUSH_ACC) ? OP_PUSH_ACC : OP_POP_ACC;
            dec.cycles = CYC_TWO; // see (RULE17)
        end else if (w == PAT_LOOP_AUX) begin
            dec.opClass = OP_LOOP_AUX; // see (RULE14)
            dec.cycles = CYC_TWO;
            needsSecond = 1'b1;
        end else if (w == PAT_JZ || w == PAT_JNZ || w == PAT_JPOS ||
                     w == PAT_JNNEG || w == PAT_JNEG || w == PAT_JNPOS) begin
            dec.opClass = OP_JUMP_ACC; // see (RULE13)
            dec.cycles = CYC_TWO;
            needsSecond = 1'b1;
            unique case (w)
                PAT_JZ: dec.cond = COND_ZERO;
                PAT_JNZ: dec.cond = COND_NONZERO;
                PAT_JPOS: dec.cond = COND_POS;
                PAT_JNNEG: dec.cond = COND_NONNEG;
                PAT_JNEG: dec.cond = COND_NEG;
                PAT_JNPOS: dec.cond = COND_NONPOS;
            endcase
        end else if (w[15:12] == PAT_OTHER_MEM_HI[7:4] &&
                     w[15:8] != PAT_OTHER_MEM_HI) begin
            dec.opClass = OP_OTHER_MEM; // see (RULE5)
        end
        // All but no-op, immediate and control classes use data memory
        dec.usesMemory = !(dec.opClass inside {OP_NOP, OP_IMM_MULTIPLY,
            OP_AUX_LOAD_IMM, OP_PTR_LOAD_IMM, OP_CALL_ACC, OP_POP_PC,
            OP_PUSH_ACC, OP_POP_ACC, OP_LOOP_AUX,
            OP_JUMP_ACC}); // see (RULE5)
    end

    // Indirect only matters for memory-operand words
    assign indirect = dec.usesMemory && wordIn[MODE_BIT]; // see (RULE5)
    assign step = (state_q == ST_FETCH) && wordValid;
    assign auxLoadEn = dec.opClass == OP_AUX_LOAD_IMM;
    assign ptrLoadEn = dec.opClass == OP_PTR_LOAD_IMM;

    // Auxiliary arithmetic; only immediate loads are applied here because
    // direct loads need the memory value the datapath returns later
    aux_unit auxRegs (
        .clock(clock),
        .rst(rst),
        .step(step && !needsSecond),
        .indirect(indirect),
        .word(wordIn),
        .loadEn(auxLoadEn),
        .loadPick(wordIn[PICK_BIT]),
        .loadValue({8'h00, wordIn[K8_W-1:0]}),
        .ptrLoadEn(ptrLoadEn),
        .ptrLoadValue(wordIn[PTR_BIT]),
        .aux0(aux0),
        .aux1(aux1),
        .auxPointer(auxPointer)
    );

    // Sequencer: fetch, then either take a second word or wait out the cycle count
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= ST_FETCH;
            waitCount_q <= 2'h0;
            firstWord_q <= WORD_ZERO;
        end else begin
            unique case (state_q)
                ST_FETCH: begin
                    if (wordValid && needsSecond) begin
                        state_q <= ST_SECOND; // see (RULE13) (RULE14)
                        firstWord_q <= wordIn;
                    end else if (wordValid && dec.cycles != CYC_ONE) begin
                        state_q <= ST_EXEC; // see (RULE7) (RULE18)
                        waitCount_q <= dec.cycles - CYC_ONE;
                    end
                end
                ST_SECOND: begin
                    if (wordValid) begin
                        state_q <= ST_FETCH; // see (RULE13) (RULE14)
                    end
                end
                ST_EXEC: begin
                    if (waitCount_q <= CYC_ONE) begin
                        state_q <= ST_FETCH;
                        waitCount_q <= 2'h0;
                    end else begin
                        waitCount_q <= waitCount_q - CYC_ONE;
                    end
                end
            endcase
        end
    end

    // Command issue: one pulse per instruction, at its last word
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            command_q <= '0;
            commandValid_q <= 1'b0;
            wordTaken_q <= 1'b0;
        end else begin
            commandValid_q <= 1'b0;
            wordTaken_q <= 1'b0;
            if (step && !needsSecond) begin
                command_q <= dec;
                commandValid_q <= 1'b1;
                wordTaken_q <= 1'b1;
            end else if (step) begin
                wordTaken_q <= 1'b1;
                command_q <= dec;
            end else if (state_q == ST_SECOND && wordValid) begin
                command_q.target <= wordIn; // see (RULE13) (RULE14)
                if (command_q.opClass == OP_LOOP_AUX) begin
                    command_q.takeJump <= (auxPointer ? aux1 : aux0) !=
                        AUX_RESET; // see (RULE14)
                end else begin
                    command_q.takeJump <= cond_true(command_q.cond,
                        accumulator); // see (RULE13)
                end
                commandValid_q <= 1'b1;
                wordTaken_q <= 1'b1;
            end
        end
    end

    // Registered views of auxiliary state and busy flag
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            aux0Out_q <= AUX_RESET;
            aux1Out_q <= AUX_RESET;
            auxPointerOut_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            aux0Out_q <= aux0;
            aux1Out_q <= aux1;
            auxPointerOut_q <= auxPointer;
            busy_q <= (state_q != ST_FETCH) || (step && (needsSecond ||
                dec.cycles != CYC_ONE));
        end
    end

endmodule // dsp_instruction_decoder

// ---- testbench/dsp_decoder_properties.sv ----
// Port checker for the instruction decoder
`timescale 1ns/1ps
module dsp_decoder_properties
    import dsp_decoder_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Fetch path and page
    input wire logic [WORD_W-1:0] wordIn,
    input wire logic wordTaken_q,
    input wire logic dataPage,
    // Command and aux state
    input wire decoded_t command_q,
    input wire logic commandValid_q,
    input wire logic [AUX_W-1:0] aux0Out_q,
    input wire logic [AUX_W-1:0] aux1Out_q,
    input wire logic auxPointerOut_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Word and page at the taking edge
    logic [WORD_W-1:0] wordSeen_q;
    logic pageSeen_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wordSeen_q <= WORD_ZERO;
            pageSeen_q <= 1'b0;
        end else begin
            wordSeen_q <= wordIn;
            pageSeen_q <= dataPage;
        end
    end
    // Memory commands other than direct aux loads
    wire logic mem = commandValid_q && command_q.usesMemory
        && !(command_q.opClass inside {OP_AUX_LOAD_DIR, OP_PTR_LOAD_IMM});
    wire logic ind = mem && wordSeen_q[MODE_BIT];
    // Selected register; sum shows any step
    wire logic [AUX_W-1:0] sel = auxPointerOut_q ? aux1Out_q : aux0Out_q;
    wire logic [AUX_W-1:0] sum = aux0Out_q + aux1Out_q;

    property p_inc; ind && wordSeen_q[INC_BIT] |=>
        sum == $past(sum) + 16'h0001; endproperty
    a_inc: assert property (p_inc)
        else $error("aux not incremented");
    property p_dec; ind && !wordSeen_q[INC_BIT] && wordSeen_q[DEC_BIT]
        |=> sum == $past(sum) - 16'h0001; endproperty
    a_dec: assert property (p_dec)
        else $error("aux not decremented");
    property p_keep; ind && wordSeen_q[INC_BIT:DEC_BIT] == 2'h0 |=>
        $stable(aux0Out_q) && $stable(aux1Out_q); endproperty
    a_keep: assert property (p_keep)
        else $error("aux changed without modify bits");
    property p_ptr; ind && !wordSeen_q[KEEP_PTR_BIT] |=>
        auxPointerOut_q == $past(wordSeen_q[PTR_BIT]); endproperty
    a_ptr: assert property (p_ptr)
        else $error("pointer not loaded");
    property p_dir; mem && !wordSeen_q[MODE_BIT] |->
        command_q.dataAddr == {pageSeen_q, wordSeen_q[DMA_HI:0]};
    endproperty
    a_dir: assert property (p_dir)
        else $error("direct address wrong");
    property p_iad; ind |-> command_q.dataAddr == sel[DATA_ADDR_W-1:0];
    endproperty
    a_iad: assert property (p_iad)
        else $error("indirect address wrong");
    property p_tbl; commandValid_q && command_q.cycles == CYC_THREE |=>
        !wordTaken_q [*2]; endproperty
    a_tbl: assert property (p_tbl)
        else $error("word taken in table op");
    property p_nop; commandValid_q && command_q.opClass == OP_NOP |->
        command_q.cycles == CYC_ONE ##1
        $stable(sum) && $stable(auxPointerOut_q); endproperty
    a_nop: assert property (p_nop)
        else $error("unknown opcode changed state");
endmodule // dsp_decoder_properties

bind dsp_instruction_decoder dsp_decoder_properties chk_u (.clock, .rst,
    .wordIn, .wordTaken_q, .dataPage, .command_q, .commandValid_q,
    .aux0Out_q, .aux1Out_q, .auxPointerOut_q);

// ---- testbench/prog_mem_model.sv ----
// Program memory model feeding words to the decoder
`timescale 1ns/1ps
module prog_mem_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Fetch handshake
    input wire logic wordTaken_q,
    output logic wordValid = 1'b0,
    output logic [15:0] wordIn = 16'h0000
);
    // Words waiting for fetch
    logic [15:0] words [$];
    // Queue one word
    task automatic push(input logic [15:0] w);
        words.push_back(w);
    endtask
    // A word stands until the decoder reports it taken
    always @(negedge clock) begin
        if (wordValid && wordTaken_q) begin
            void'(words.pop_front());
        end
        if (rst || words.size() == 0) begin
            wordValid <= 1'b0;
            // Idle bus must not keep showing the last word
            wordIn <= ~wordIn;
        end else begin
            wordValid <= 1'b1;
            wordIn <= words[0];
        end
    end
endmodule // prog_mem_model

// ---- testbench/dsp_instruction_decoder_test.sv ----
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
module dsp_instruction_decoder_test;
    import dsp_decoder_pkg::*;
    // Stimulus and observed signals
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic dataPage = 1'b0;
    logic wordValid, wordTaken_q, commandValid_q, auxPointerOut_q, busy_q;
    logic [15:0] wordIn, aux0Out_q, aux1Out_q;
    decoded_t command_q;
    int fails = 0;
    int compares = 0;
    // Branch words and their conditions
    logic [15:0] jumpWord [6] = '{PAT_JZ, PAT_JNZ, PAT_JPOS, PAT_JNNEG,
        PAT_JNEG, PAT_JNPOS};
    jump_cond_t jumpCond [6] = '{COND_ZERO, COND_NONZERO, COND_POS,
        COND_NONNEG, COND_NEG, COND_NONPOS};
    // One-word instructions, class and length
    logic [15:0] soloWord [12] = '{PAT_CALL_ACC, PAT_POP_PC, PAT_PUSH_ACC,
        PAT_POP_ACC, 16'h6701, 16'h7d01, 16'h6101, 16'h6501, 16'h6901,
        16'h6b01, 16'h8123, 16'he000};
    op_class_t soloClass [12] = '{OP_CALL_ACC, OP_POP_PC, OP_PUSH_ACC,
        OP_POP_ACC, OP_TABLE_READ, OP_TABLE_WRITE, OP_PLUS_UNEXT,
        OP_CLEAR_LOAD_HI, OP_DATA_SHIFT, OP_T_LOAD_MOVE, OP_IMM_MULTIPLY,
        OP_NOP};
    logic [1:0] soloCyc [12] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h1,
        2'h1, 2'h1, 2'h1, 2'h1, 2'h1};
    // Accumulator held at zero
    dsp_instruction_decoder dut_u (.clock, .rst, .wordValid, .wordIn,
        .wordTaken_q, .dataPage, .accumulator(32'h0000_0000), .command_q,
        .commandValid_q, .aux0Out_q, .aux1Out_q, .auxPointerOut_q,
        .busy_q);
    prog_mem_model mem_u (.clock, .rst, .wordTaken_q, .wordValid, .wordIn);
    always #2.5 clock = ~clock;
    // Compare one value
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Issue words (a nonzero t is a second word), check class and length
    task automatic op(input logic [15:0] w, input logic [15:0] t,
        input op_class_t c, input logic [1:0] n);
        int k = 0;
        @(posedge clock);
        mem_u.push(w);
        if (t != 16'h0) mem_u.push(t);
        @(negedge clock);
        while (commandValid_q !== 1'b1 && k < 40) begin
            @(negedge clock);
            k++;
        end
        chk(16'(command_q.opClass), 16'(c));
        chk(16'(command_q.cycles), 16'(n));
        chk(16'(busy_q), 16'(n != CYC_ONE));
    endtask
    task automatic solo(input int i);
        op(soloWord[i], 16'h0, soloClass[i], soloCyc[i]);
    endtask
    // Verdict
    task automatic close_out();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Watchdog: a hang is a failure
    initial begin
        #20000;
        fails++;
        close_out();
    end
    initial begin
        repeat (6) @(negedge clock);
        rst = 1'b0;
        op(16'h7005, 16'h0, OP_AUX_LOAD_IMM, 2'h1);
        op(16'h7180, 16'h0, OP_AUX_LOAD_IMM, 2'h1);
        op(16'h6881, 16'h0, OP_PTR_LOAD_IMM, 2'h1);
        repeat (2) @(negedge clock);
        chk(aux0Out_q, 16'h0005);
        chk(aux1Out_q, 16'h0080);
        chk(16'(auxPointerOut_q), 16'h0001);
        op(16'h03a8, 16'h0, OP_ADD_SHIFT, 2'h1);
        chk(16'(command_q.dataAddr), 16'h0080);
        chk(16'(command_q.loadShift), 16'h0003);
        repeat (2) @(negedge clock);
        chk(aux1Out_q, 16'h0081);
        op(16'h1f90, 16'h0, OP_SUB_SHIFT, 2'h1);
        repeat (2) @(negedge clock);
        chk(aux1Out_q, 16'h0080);
        chk(16'(auxPointerOut_q), 16'h0000);
        op(16'h2088, 16'h0, OP_LOAD_SHIFT, 2'h1);
        op(16'h7000, 16'h0, OP_AUX_LOAD_IMM, 2'h1);
        op(16'h1090, 16'h0, OP_SUB_SHIFT, 2'h1);
        repeat (2) @(negedge clock);
        chk(aux0Out_q, 16'hffff);
        op(PAT_LOOP_AUX, 16'h0123, OP_LOOP_AUX, 2'h2);
        chk(16'(command_q.takeJump), 16'h0001);
        chk(command_q.target, 16'h0123);
        dataPage = 1'b1;
        op(16'h0012, 16'h0, OP_ADD_SHIFT, 2'h1);
        chk(16'(command_q.dataAddr), 16'h0092);
        for (int i = 0; i < 8; i++) begin
            op(16'h4001 | 16'(i << 8), 16'h0, OP_PORT_IN, 2'h2);
            chk(16'(command_q.ioChannel), 16'(i));
            op(16'h4801 | 16'(i << 8), 16'h0, OP_PORT_OUT, 2'h2);
        end
        for (int i = 0; i < 6; i++) begin
            op(jumpWord[i], 16'h0abc, OP_JUMP_ACC, 2'h2);
            chk(16'(command_q.cond), 16'(jumpCond[i]));
            chk(16'(command_q.takeJump), (16'h0029 >> i) & 16'h0001);
            chk(command_q.target, 16'h0abc);
        end
        for (int i = 0; i < 4; i++) solo(i);
        for (int i = 4; i < 6; i++) solo(i);
        for (int i = 6; i < 10; i++) solo(i);
        solo(10);
        chk(16'(command_q.immediate), 16'h0123);
        chk(16'(command_q.usesMemory), 16'h0000);
        solo(11);
        op(16'h5c01, 16'h0, OP_UPPER_STORE, 2'h1);
        chk(16'(command_q.storeShift), 16'h0004);
        // Second table op queued at once must wait out the first
        op(16'h6701, 16'h7d01, OP_TABLE_READ, 2'h3);
        repeat (8) @(negedge clock);
        close_out();
    end
endmodule // dsp_instruction_decoder_test
